// *** design/iqf_serial_out.sv ***
// iq serial output formatter: control word decode, slot timing, serial pin drivers
// Functional notes
// - two-bit code picks 16/24/32/38 bit words
// - order bit 0 lsb first, 1 msb first
// - top three bits route word; 110 io format
// - update bit 0 this word, 1 all pending
// - interleave sends i then q on i pin
// - six-bit slot number among 64 slots
// - phase bit picks rising or falling stable edge
// - duty bit: one clock active or 50%
// - clock only during words, or continuous
// - clock driver off, on, or slot-only
// - strobe polarity high or low active
// - strobe before word or during word
// - strobe driver off, on, or slot-only
// - polarity bits invert i and q data
// - i driver off, on, or slot-only
// - q driver off, on, or slot-only
// - 13-bit rate compare value sets bit period of rate+1 clocks
`timescale 1ns/1ns
module iqf_serial_out (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_sys_rst,
  input  wire logic [iqf_pkg::CW_W-1:0] i_ctl_word,
  input  wire logic                 i_ctl_load,
  input  wire iqf_pkg::iqf_sample_t i_samp,
  output logic                      o_i_data,
  output logic                      o_i_oe_n,
  output logic                      o_q_data,
  output logic                      o_q_oe_n,
  output logic                      o_sclk,
  output logic                      o_sclk_oe_n,
  output logic                      o_wstb,
  output logic                      o_wstb_oe_n,
  output logic                      o_busy
);
  import iqf_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_LEAD, ST_RUN} iqf_state_t;

  function automatic logic [6:0] iqf_wbits(input logic [1:0] code);
    unique case (code)
      WL_16:   iqf_wbits = WBITS_16;
      WL_24:   iqf_wbits = WBITS_24;
      WL_32:   iqf_wbits = WBITS_32;
      default: iqf_wbits = WBITS_38;
    endcase
  endfunction

  // word is the top wl bits of the sample; k counts bits already sent
  function automatic logic iqf_pick(input logic [SAMP_W-1:0] s, input logic [6:0] k,
                                    input logic [6:0] wl, input logic msb);
    logic [6:0] idx;
    idx = msb ? 7'(7'd37 - k) : 7'(7'd38 - wl + k);
    iqf_pick = s[idx[5:0]];
  endfunction

  function automatic logic iqf_drv_n(input logic [1:0] mode, input logic in_slot);
    iqf_drv_n = !((mode == TRI_ON) || (mode[1] && in_slot));
  endfunction

  // ---------------- control words
  iqf_outfmt_t pend_out, act_out, next_pend_out, next_act_out;
  iqf_iofmt_t  pend_io, act_io, next_pend_io, next_act_io;
  iqf_outfmt_t new_out;
  iqf_iofmt_t  new_io;
  logic [2:0]  dest;
  logic        upd_all;

  always_comb begin
    dest    = i_ctl_word[DEST_HI:DEST_LO];
    upd_all = i_ctl_word[UPD_BIT];
    new_out = '{wlen: i_ctl_word[WLEN_HI:WLEN_LO], msb_first: i_ctl_word[ORDER_BIT]};
    new_io  = '{interleave: i_ctl_word[ILV_BIT], tslot: i_ctl_word[SLOT_HI:SLOT_LO],
                clk_phase: i_ctl_word[CPHASE_BIT], duty50: i_ctl_word[DUTY_BIT],
                clk_cont: i_ctl_word[CONT_BIT], clk_tri: i_ctl_word[CTRI_HI:CTRI_LO],
                stb_pol: i_ctl_word[SPOL_BIT], stb_loc: i_ctl_word[SLOC_BIT],
                stb_tri: i_ctl_word[STRI_HI:STRI_LO], i_pol: i_ctl_word[IPOL_BIT],
                i_tri: i_ctl_word[ITRI_HI:ITRI_LO], q_pol: i_ctl_word[QPOL_BIT],
                q_tri: i_ctl_word[QTRI_HI:QTRI_LO], rate: i_ctl_word[RATE_HI:RATE_LO]};
    next_pend_out = pend_out;
    next_pend_io  = pend_io;
    next_act_out  = act_out;
    next_act_io   = act_io;
    if (i_ctl_load && dest == DEST_OUTFMT) begin
      next_pend_out = new_out;
      next_act_out  = new_out;
      if (upd_all) begin
        next_act_io = pend_io;
      end
    end else if (i_ctl_load && dest == DEST_IOFMT) begin
      next_pend_io = new_io;
      next_act_io  = new_io;
      if (upd_all) begin
        next_act_out = pend_out;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pend_out <= OUTFMT_RST;
      act_out  <= OUTFMT_RST;
      pend_io  <= IOFMT_RST;
      act_io   <= IOFMT_RST;
    end else begin
      pend_out <= next_pend_out;
      act_out  <= next_act_out;
      pend_io  <= next_pend_io;
      act_io   <= next_act_io;
    end
  end

  // ---------------- bit timer and frame sequencer
  iqf_state_t        state, next_state;
  logic [12:0]       timer, next_timer;
  logic [6:0]        bit_idx, next_bit_idx;
  logic [5:0]        slot_cnt, next_slot_cnt;
  logic [SAMP_W-1:0] hold_i, hold_q, next_hold_i, next_hold_q;
  logic [6:0]        wl;
  logic [7:0]        slot_len;
  logic              bit_wrap, slot_end, sending;

  always_comb begin
    wl       = iqf_wbits(act_out.wlen);
    slot_len = act_io.interleave ? {wl, 1'b0} : {1'b0, wl};
    // free-running so a continuous clock keeps going between frames
    bit_wrap = (timer >= act_io.rate);
    slot_end = bit_wrap && ({1'b0, bit_idx} == 8'(slot_len - 8'd1));
    sending  = (state == ST_RUN) && (slot_cnt == act_io.tslot);
    next_timer    = bit_wrap ? 13'h0000 : 13'(timer + 13'd1);
    next_state    = state;
    next_bit_idx  = bit_idx;
    next_slot_cnt = slot_cnt;
    next_hold_i   = hold_i;
    next_hold_q   = hold_q;
    unique case (state)
      ST_IDLE: begin
        // samples arriving mid-frame are dropped; one frame per sample
        if (i_samp.valid) begin
          next_hold_i = i_samp.i;
          next_hold_q = i_samp.q;
          next_state  = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (bit_wrap) begin
          next_state = ST_LEAD;
        end
      end
      ST_LEAD: begin
        if (bit_wrap) begin
          next_state    = ST_RUN;
          next_bit_idx  = 7'h00;
          next_slot_cnt = 6'h00;
        end
      end
      ST_RUN: begin
        if (slot_end) begin
          next_bit_idx = 7'h00;
          if (slot_cnt == LAST_SLOT) begin
            next_state = ST_IDLE;
          end else begin
            next_slot_cnt = 6'(slot_cnt + 6'd1);
          end
        end else if (bit_wrap) begin
          next_bit_idx = 7'(bit_idx + 7'd1);
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      state    <= ST_IDLE;
      timer    <= 13'h0000;
      bit_idx  <= 7'h00;
      slot_cnt <= 6'h00;
      hold_i   <= '0;
      hold_q   <= '0;
    end else begin
      state    <= next_state;
      timer    <= next_timer;
      bit_idx  <= next_bit_idx;
      slot_cnt <= next_slot_cnt;
      hold_i   <= next_hold_i;
      hold_q   <= next_hold_q;
    end
  end

  // ---------------- pin values
  logic       q_phase, bit_i, bit_q, pulse, stb_on, stb_prior;
  logic [6:0] k;
  logic [12:0] half;
  logic       next_i_data, next_q_data, next_sclk, next_wstb;
  logic       next_i_oe_n, next_q_oe_n, next_sclk_oe_n, next_wstb_oe_n;

  always_comb begin
    q_phase = act_io.interleave && (bit_idx >= wl);
    k       = q_phase ? 7'(bit_idx - wl) : bit_idx;
    bit_i   = q_phase ? iqf_pick(hold_q, k, wl, act_out.msb_first)
                      : iqf_pick(hold_i, k, wl, act_out.msb_first);
    bit_q   = iqf_pick(hold_q, k, wl, act_out.msb_first);
    half    = 13'((act_io.rate + 13'd1) >> 1);
    pulse   = act_io.duty50 ? (timer < half) : (timer == 13'h0000);
    // active phase leads the bit so the closing edge lands mid-bit with duty50, one clock in otherwise
    next_sclk = (((act_io.clk_cont || sending) && pulse) ^ !act_io.clk_phase);
    stb_prior = ((state == ST_LEAD) && (act_io.tslot == 6'h00)) ||
                // no strobe after the last slot; slot 0 is announced in the lead period
                ((state == ST_RUN) && (slot_cnt != LAST_SLOT) && (6'(slot_cnt + 6'd1) == act_io.tslot) &&
                 ({1'b0, bit_idx} == 8'(slot_len - 8'd1))) ||
                (sending && act_io.interleave && (bit_idx == 7'(wl - 7'd1)));
    stb_on    = act_io.stb_loc ? sending : stb_prior;
    next_wstb = stb_on ^ act_io.stb_pol;
    next_i_data = (sending && bit_i) ^ act_io.i_pol;
    next_q_data = (sending && !act_io.interleave && bit_q) ^ act_io.q_pol;
    next_sclk_oe_n = iqf_drv_n(act_io.clk_tri, sending);
    next_wstb_oe_n = iqf_drv_n(act_io.stb_tri, sending);
    next_i_oe_n    = iqf_drv_n(act_io.i_tri, sending);
    next_q_oe_n    = iqf_drv_n(act_io.q_tri, sending);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_i_data    <= 1'b0;
      o_q_data    <= 1'b0;
      o_sclk      <= 1'b1;
      o_wstb      <= 1'b0;
      o_i_oe_n    <= 1'b1;
      o_q_oe_n    <= 1'b1;
      o_sclk_oe_n <= 1'b1;
      o_wstb_oe_n <= 1'b1;
      o_busy      <= 1'b0;
    end else begin
      o_i_data    <= next_i_data;
      o_q_data    <= next_q_data;
      o_sclk      <= next_sclk;
      o_wstb      <= next_wstb;
      o_i_oe_n    <= next_i_oe_n;
      o_q_oe_n    <= next_q_oe_n;
      o_sclk_oe_n <= next_sclk_oe_n;
      o_wstb_oe_n <= next_wstb_oe_n;
      o_busy      <= (next_state != ST_IDLE);
    end
  end

  // ---------------- checks
  a_wlen_map: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (act_out.wlen == 2'b11) |-> (wl == 7'd38)) else $error("word length code 11 not 38 bits");
  a_route_iofmt: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_ctl_load && i_ctl_word[39:37] == 3'b110 && !i_ctl_word[36]) |=>
    (act_io.rate == $past(i_ctl_word[12:0]))) else $error("io format word not activated");
  a_update_all: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (i_ctl_load && i_ctl_word[39:37] == 3'b101 && i_ctl_word[36]) |=>
    (act_io == $past(pend_io))) else $error("update all missed pending io word");
  a_slot_wrap: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (state == ST_RUN && slot_end && slot_cnt == 6'd63) |=> (state == ST_IDLE))
    else $error("frame did not end after slot 63");
  a_clk_idle: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (state == ST_IDLE && !act_io.clk_cont) |=> (o_sclk == !$past(act_io.clk_phase)))
    else $error("clock toggled outside words");
  a_clk_cont: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (act_io.clk_cont && timer == 13'd0) |=> (o_sclk == $past(act_io.clk_phase)))
    else $error("active clock phase missing at bit start");
  a_clk_tri_off: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (act_io.clk_tri == 2'b00) |=> o_sclk_oe_n) else $error("clock driven while off");
  a_stb_pol: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (!stb_on && act_io.stb_pol) |=> o_wstb) else $error("idle strobe level wrong");
  a_i_invert: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    sending |=> (o_i_data == ($past(bit_i) ^ $past(act_io.i_pol)))) else $error("i data polarity wrong");
  a_auto_slot: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (act_io.i_tri[1] && !sending) |=> o_i_oe_n) else $error("i driven outside slot");
  a_q_on: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (act_io.q_tri == 2'b01) |=> !o_q_oe_n) else $error("q not driven when enabled");
  a_stb_tri_off: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (act_io.stb_tri == TRI_OFF) |=> o_wstb_oe_n)
    else $error("strobe driven while off");
  a_i_tri_off: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (act_io.i_tri == TRI_OFF) |=> o_i_oe_n)
    else $error("i driven while off");
  a_q_auto_slot: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (act_io.q_tri[1] && !sending) |=> o_q_oe_n)
    else $error("q driven outside slot");
  a_clk_on: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (act_io.clk_tri == TRI_ON) |=> !o_sclk_oe_n)
    else $error("clock not driven when enabled");
  a_ilv_q_quiet: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    act_io.interleave |=> (o_q_data == $past(act_io.q_pol)))
    else $error("q pin carried data while interleaved");
  a_msb_first: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (sending && act_out.msb_first && bit_idx == 7'h00) |=> (o_i_data == ($past(hold_i[SAMP_W-1]) ^ $past(act_io.i_pol))))
    else $error("first bit not the word msb");
  a_lsb_first: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (sending && !act_out.msb_first && act_out.wlen == 2'h3 && bit_idx == 7'h00) |=>
    (o_i_data == ($past(hold_i[0]) ^ $past(act_io.i_pol)))) else $error("first bit not the word lsb");
  a_slot_step: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (state == ST_RUN && slot_end && slot_cnt != LAST_SLOT) |=> (slot_cnt == 6'($past(slot_cnt) + 6'h01)))
    else $error("slot counter did not advance");
  a_stb_lead: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (state == ST_LEAD && act_io.tslot == 6'h00 && !act_io.stb_loc) |=> (o_wstb == !$past(act_io.stb_pol)))
    else $error("strobe missing before slot 0");
  a_stb_during: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
    (sending && act_io.stb_loc) |=> (o_wstb == !$past(act_io.stb_pol)))
    else $error("strobe missing during word");
endmodule

// *** design/iqf_pkg.sv ***
// package for the iq serial output formatter: control word layout, config types
package iqf_pkg;
  localparam int CW_W         = 40;
  localparam int DEST_HI      = 39;
  localparam int DEST_LO      = 37;
  localparam int UPD_BIT      = 36;
  localparam logic [2:0] DEST_OUTFMT = 3'h5;
  localparam logic [2:0] DEST_IOFMT  = 3'h6;
  // decimation output config word fields
  localparam int WLEN_HI      = 2;
  localparam int WLEN_LO      = 1;
  localparam int ORDER_BIT    = 0;
  // io format config word fields
  localparam int ILV_BIT      = 35;
  localparam int SLOT_HI      = 34;
  localparam int SLOT_LO      = 29;
  localparam int CPHASE_BIT   = 28;
  localparam int DUTY_BIT     = 27;
  localparam int CONT_BIT     = 26;
  localparam int CTRI_HI      = 25;
  localparam int CTRI_LO      = 24;
  localparam int SPOL_BIT     = 23;
  localparam int SLOC_BIT     = 22;
  localparam int STRI_HI      = 21;
  localparam int STRI_LO      = 20;
  localparam int IPOL_BIT     = 19;
  localparam int ITRI_HI      = 18;
  localparam int ITRI_LO      = 17;
  localparam int QPOL_BIT     = 16;
  localparam int QTRI_HI      = 15;
  localparam int QTRI_LO      = 14;
  localparam int RATE_HI      = 12;
  localparam int RATE_LO      = 0;
  // word length codes and bit counts
  localparam logic [1:0] WL_16 = 2'h0;
  localparam logic [1:0] WL_24 = 2'h1;
  localparam logic [1:0] WL_32 = 2'h2;
  localparam logic [6:0] WBITS_16 = 7'h10;
  localparam logic [6:0] WBITS_24 = 7'h18;
  localparam logic [6:0] WBITS_32 = 7'h20;
  localparam logic [6:0] WBITS_38 = 7'h26;
  localparam int SAMP_W       = 38;
  localparam logic [5:0] LAST_SLOT  = 6'h3f;
  localparam logic [12:0] RATE_RST  = 13'h0002;
  // driver modes
  localparam logic [1:0] TRI_OFF = 2'h0;
  localparam logic [1:0] TRI_ON  = 2'h1;

  typedef struct packed {
    logic [1:0] wlen;
    logic       msb_first;
  } iqf_outfmt_t;

  typedef struct packed {
    logic        interleave;
    logic [5:0]  tslot;
    logic        clk_phase;
    logic        duty50;
    logic        clk_cont;
    logic [1:0]  clk_tri;
    logic        stb_pol;
    logic        stb_loc;
    logic [1:0]  stb_tri;
    logic        i_pol;
    logic [1:0]  i_tri;
    logic        q_pol;
    logic [1:0]  q_tri;
    logic [12:0] rate;
  } iqf_iofmt_t;

  typedef struct packed {
    logic              valid;
    logic [SAMP_W-1:0] i;
    logic [SAMP_W-1:0] q;
  } iqf_sample_t;

  localparam iqf_outfmt_t OUTFMT_RST = '{wlen: WL_16, msb_first: 1'b0};
  localparam iqf_iofmt_t  IOFMT_RST  = '{rate: RATE_RST, default: '0};
endpackage

// *** tb/iqf_rx_model.sv ***
// receive port model: takes bits on the stable clock edge and counts pin activity
`timescale 1ns/1ns
module iqf_rx_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_clr,
  input  wire logic        i_phase,
  input  wire logic        i_stb_pol,
  input  wire logic [7:0]  i_pins,
  output logic      [63:0] o_rx_i,
  output logic      [63:0] o_rx_q,
  output int               o_edges,
  output int               o_clk_act,
  output int               o_stb_act,
  output int               o_ioe,
  output int               o_qoe
);
  logic iw, qw, cw, sw, cw_d, cdrv_d;
  // a released line shows the inverse of the pin value, never a kept level
  assign iw = i_pins[7] ^ i_pins[6];
  assign qw = i_pins[5] ^ i_pins[4];
  assign cw = i_pins[3] ^ i_pins[2];
  assign sw = i_pins[1] ^ i_pins[0];
  always @(posedge i_core_clk) begin
    cw_d <= cw;
    cdrv_d <= ~i_pins[2];
    if (i_clr) begin
      o_rx_i <= '0;
      o_rx_q <= '0;
      o_edges <= 0;
      o_clk_act <= 0;
      o_stb_act <= 0;
      o_ioe <= 0;
      o_qoe <= 0;
    end else begin
      // an edge across a release is no edge: both cycles must be driven
      if (cdrv_d && !i_pins[2] && (i_phase ? (cw_d && !cw) : (!cw_d && cw))) begin
        o_rx_i <= {o_rx_i[62:0], iw};
        o_rx_q <= {o_rx_q[62:0], qw};
        o_edges <= o_edges + 1;
      end
      if (!i_pins[2] && cw == i_phase) o_clk_act <= o_clk_act + 1;
      if (!i_pins[0] && sw != i_stb_pol) o_stb_act <= o_stb_act + 1;
      if (!i_pins[6]) o_ioe <= o_ioe + 1;
      if (!i_pins[4]) o_qoe <= o_qoe + 1;
    end
  end
endmodule

// *** tb/tb_iqf_serial_out.sv ***
// testbench for the iq serial output formatter: config loads, frame capture, pin checks
`timescale 1ns/1ns
module tb_iqf_serial_out;
  import iqf_pkg::*;
  logic i_core_clk, i_sys_rst, i_ctl_load, clr;
  logic [CW_W-1:0] i_ctl_word;
  iqf_sample_t i_samp;
  logic o_i_data, o_i_oe_n, o_q_data, o_q_oe_n, o_sclk, o_sclk_oe_n, o_wstb, o_wstb_oe_n, o_busy;
  logic [63:0] rx_i, rx_q, e, mask;
  int edges, clk_act, stb_act, ioe, qoe, error_cnt, check_count, cyc, n, w, k;
  iqf_iofmt_t c;
  iqf_iofmt_t cfg [4];
  logic [1:0] wl [4] = '{WL_16, WL_24, WL_32, 2'h3};
  logic msb [4] = '{1'h1, 1'h0, 1'h1, 1'h0};
  logic [SAMP_W-1:0] si [4] = '{38'h25_a5c3_9e17, 38'h0f_0123_4567, 38'h3a_5a5a_c3c3, 38'h11_fedc_ba98};
  logic [SAMP_W-1:0] sq [4] = '{38'h1c_3c3c_a5a5, 38'h30_89ab_cdef, 38'h05_f00f_1234, 38'h2e_7654_3210};

  iqf_serial_out i_iqf_serial_out (
    .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_ctl_word(i_ctl_word), .i_ctl_load(i_ctl_load),
    .i_samp(i_samp), .o_i_data(o_i_data), .o_i_oe_n(o_i_oe_n), .o_q_data(o_q_data), .o_q_oe_n(o_q_oe_n),
    .o_sclk(o_sclk), .o_sclk_oe_n(o_sclk_oe_n), .o_wstb(o_wstb), .o_wstb_oe_n(o_wstb_oe_n), .o_busy(o_busy));

  iqf_rx_model i_iqf_rx_model (
    .i_core_clk(i_core_clk), .i_clr(clr), .i_phase(c.clk_phase), .i_stb_pol(c.stb_pol),
    .i_pins({o_i_data, o_i_oe_n, o_q_data, o_q_oe_n, o_sclk, o_sclk_oe_n, o_wstb, o_wstb_oe_n}),
    .o_rx_i(rx_i), .o_rx_q(rx_q), .o_edges(edges), .o_clk_act(clk_act), .o_stb_act(stb_act),
    .o_ioe(ioe), .o_qoe(qoe));

  task automatic final_report;
    if (error_cnt == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic load(input logic [CW_W-1:0] word);
    i_ctl_word <= word;
    i_ctl_load <= 1'h1;
    @(posedge i_core_clk);
  endtask

  function automatic int wb(input logic [1:0] code);
    return code == 2'h0 ? 16 : code == 2'h1 ? 24 : code == 2'h2 ? 32 : 38;
  endfunction

  // bits in line order, first sent ends up highest
  function automatic logic [63:0] seq(input logic [SAMP_W-1:0] s, input int wd, input logic m);
    logic [63:0] r;
    r = '0;
    for (int j = 0; j < wd; j++) r = {r[62:0], m ? s[SAMP_W-1-j] : s[SAMP_W-wd+j]};
    return r;
  endfunction

  initial begin
    i_core_clk = 1'h0;
    forever #25 i_core_clk = ~i_core_clk;
  end

  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    i_sys_rst = 1'h1;
    i_ctl_load = 1'h0;
    i_ctl_word = '0;
    i_samp = '0;
    clr = 1'h1;
    c = '0;
    cyc = 0;
    error_cnt = 0;
    check_count = 0;
    cfg[0] = '{1'h0, 6'h00, 1'h0, 1'h0, 1'h1, 2'h2, 1'h0, 1'h0, 2'h1, 1'h0, 2'h1, 1'h0, 2'h1, 13'h0002};
    cfg[1] = '{1'h0, 6'h3f, 1'h1, 1'h1, 1'h0, 2'h2, 1'h1, 1'h0, 2'h1, 1'h1, 2'h3, 1'h1, 2'h1, 13'h0003};
    cfg[2] = '{1'h1, 6'h05, 1'h0, 1'h0, 1'h0, 2'h1, 1'h0, 1'h0, 2'h1, 1'h0, 2'h2, 1'h0, 2'h0, 13'h0002};
    cfg[3] = '{1'h0, 6'h01, 1'h1, 1'h0, 1'h0, 2'h3, 1'h0, 1'h1, 2'h1, 1'h0, 2'h1, 1'h1, 2'h2, 13'h0002};
    repeat (6) @(posedge i_core_clk);
    @(negedge i_core_clk);
    chk_val({o_i_oe_n, o_q_oe_n, o_sclk_oe_n, o_wstb_oe_n, o_busy}, 64'h001e);
    @(posedge i_core_clk);
    i_sys_rst <= 1'h0;
    for (int r = 0; r < 4; r++) begin
      c = cfg[r];
      w = wb(wl[r]);
      n = c.interleave ? 2 * w : w;
      mask = (64'h1 << n) - 64'h1;
      load({DEST_IOFMT, 1'h0, c[34:13], 1'h0, c[12:0]});
      load({DEST_OUTFMT, 1'h1, 33'h0, wl[r], msb[r]});
      // unrouted destination carrying an all-off config must change nothing
      load({3'h7, 1'h1, 36'h0});
      i_ctl_load <= 1'h0;
      repeat (2) @(posedge i_core_clk);
      @(negedge i_core_clk);
      chk_val(o_busy, 64'h0);
      if (c.clk_tri == TRI_ON) chk_val(o_sclk, !c.clk_phase);
      if (c.clk_tri[1]) chk_val(o_sclk_oe_n, 64'h1);
      chk_val(o_wstb, c.stb_pol);
      @(posedge i_core_clk);
      clr <= 1'h0;
      i_samp <= '{1'h1, si[r], sq[r]};
      @(posedge i_core_clk);
      i_samp.valid <= 1'h0;
      @(negedge i_core_clk);
      chk_val(o_busy, 64'h1);
      for (k = 0; k < 20000 && o_busy === 1'h1; k++) @(posedge i_core_clk);
      repeat (2) @(negedge i_core_clk);
      chk_val(o_busy, 64'h0);
      e = seq(si[r], w, msb[r]);
      if (c.interleave) e = (e << w) | seq(sq[r], w, msb[r]);
      chk_val(rx_i, e ^ ({64{c.i_pol}} & mask));
      chk_val(64'(edges), 64'(n));
      if (!c.interleave) chk_val(rx_q, seq(sq[r], w, msb[r]) ^ ({64{c.q_pol}} & mask));
      chk_val(64'(clk_act), 64'(n * (c.duty50 ? (int'(c.rate) + 1) / 2 : 1)));
      chk_val(64'(stb_act), 64'((c.stb_loc ? n : c.interleave ? 2 : 1) * (int'(c.rate) + 1)));
      if (c.i_tri[1]) chk_val(64'(ioe), 64'(n * (int'(c.rate) + 1)));
      if (c.q_tri != TRI_ON) chk_val(64'(qoe), 64'(c.q_tri[1] ? w * (int'(c.rate) + 1) : 0));
      @(posedge i_core_clk);
      clr <= 1'h1;
    end
    final_report();
  end
endmodule
